// *** hw/i2m_master.sv ***
// i2m_master: single-master i2c segment controller behind an axi4-lite slave.
// assumes external pull-ups on scl/sda and a 200 mhz clk_sys.
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "i2m_cfg.svh"
module i2m_master import i2m_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // i2c pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // interrupt
  output logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  function automatic logic [19:0] i2m_period(input logic [3:0] lin, input logic [3:0] ex);
    i2m_period = 20'({16'h0, lin} + 20'h1) << ex;
  endfunction : i2m_period

  // --------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic wr_fire, rd_fire, wr_hit;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] rd_word;
  logic rd_hit;

  // engine and register state, declared here for the read mux
  i2m_state_t st_reg, st_next;
  logic [1:0] mode_reg, mode_next;
  logic [3:0] lin_reg, lin_next, pow_reg, pow_next, cmd_reg, cmd_next, stat_reg, stat_next;
  logic ack_ctl_reg, ack_ctl_next, tx_full_reg, tx_full_next, rx_full_reg, rx_full_next;
  logic [7:0] data_reg, data_next, shift_reg, shift_next;
  logic [5:0] evt_reg, evt_next, evt_en_reg, evt_en_next;
  logic top_en_reg, top_en_next, irq_reg, irq_next;

  always_comb begin
    wr_addr = 8'(awaddr_reg);
    rd_addr = 8'(s_axi_araddr);
    wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
    wr_hit = (wr_addr[1:0] == 2'h0) && (wr_addr <= `I2M_OFF_TOPEN) && (wr_addr != `I2M_OFF_STAT);
    rd_fire = s_axi_arvalid && arready_reg;
    rd_hit = 1'b1;
    rd_word = 32'h0;
    case (rd_addr)
      `I2M_OFF_MODE: rd_word = {30'h0, mode_reg};
      `I2M_OFF_LIN: rd_word = {28'h0, lin_reg};
      `I2M_OFF_POW: rd_word = {28'h0, pow_reg};
      `I2M_OFF_CMD: rd_word = {28'h0, cmd_reg};
      `I2M_OFF_OPT: rd_word = {31'h0, ack_ctl_reg};
      `I2M_OFF_STAT: rd_word = {28'h0, stat_reg};
      `I2M_OFF_DATA: rd_word = {24'h0, data_reg};
      `I2M_OFF_EVT: rd_word = {26'h0, evt_reg};
      `I2M_OFF_EVTEN: rd_word = {26'h0, evt_en_reg};
      `I2M_OFF_TOPEN: rd_word = {31'h0, top_en_reg};
      default: rd_hit = 1'b0;
    endcase
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? `I2M_RESP_OKAY : `I2M_RESP_SLVERR;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rdata_next = rd_word;
      rresp_next = rd_hit ? `I2M_RESP_OKAY : `I2M_RESP_SLVERR;
    end
    // one write and one read in flight; ready drops once an item is held
    awready_next = !aw_got_next && !bvalid_next;
    wready_next = !w_got_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h0;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      arready_reg <= arready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // --------------------------------------------------------------
  // segment engine and registers
  // --------------------------------------------------------------
  logic scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg;
  logic [17:0] acc_reg, acc_next;
  logic [19:0] cnt_reg, cnt_next, per, half, q1, q3;
  logic [3:0] bit_reg, bit_next;
  i2m_drive_t drv_reg, drv_next;
  logic tick, mode_ok, stall, wr_en, is_send;
  logic [7:0] wd;
  logic [5:0] evt_set;

  always_comb begin
    wd = wdata_reg[7:0];
    wr_en = wr_fire && wr_hit && wstrb_reg[0];
    mode_ok = (mode_reg == `I2M_MODE_I2C);
    per = i2m_period(lin_reg, pow_reg);
    half = per >> 1;
    q1 = per >> 2;
    q3 = half + q1;
    tick = (acc_reg + `I2M_REF_KHZ) >= `I2M_CLK_KHZ;
    acc_next = tick ? 18'(acc_reg + `I2M_REF_KHZ - `I2M_CLK_KHZ) : 18'(acc_reg + `I2M_REF_KHZ);
    // clock stretching: hold the count while a released scl still reads low
    stall = (cnt_reg > half) && !drv_reg.scl_low && !scl_s2_reg;
    is_send = cmd_reg[`I2M_CMD_SEND];
    st_next = st_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    drv_next = drv_reg;
    shift_next = shift_reg;
    cmd_next = cmd_reg;
    stat_next = stat_reg;
    data_next = data_reg;
    tx_full_next = tx_full_reg;
    rx_full_next = rx_full_reg;
    evt_set = 6'h0;
    mode_next = mode_reg;
    lin_next = lin_reg;
    pow_next = pow_reg;
    ack_ctl_next = ack_ctl_reg;
    evt_en_next = evt_en_reg;
    top_en_next = top_en_reg;
    if (rd_fire && rd_addr == `I2M_OFF_DATA) begin
      rx_full_next = 1'b0;
    end
    if (wr_en) begin
      case (wr_addr)
        `I2M_OFF_MODE: mode_next = wd[1:0];
        `I2M_OFF_LIN: lin_next = wd[3:0];
        `I2M_OFF_POW: pow_next = wd[3:0];
        `I2M_OFF_OPT: ack_ctl_next = wd[0];
        `I2M_OFF_EVTEN: evt_en_next = wd[5:0];
        `I2M_OFF_TOPEN: top_en_next = wd[0];
        `I2M_OFF_DATA: begin
          data_next = wd;
          tx_full_next = 1'b1;
        end
        `I2M_OFF_CMD: begin
          // more than one bit, or any write while busy, is dropped
          if (st_reg == I2M_ST_IDLE && cmd_reg == 4'h0 && mode_ok && $onehot(wd[3:0])) begin
            cmd_next = wd[3:0];
            stat_next[2:0] = 3'h0;
          end
        end
        default: cmd_next = cmd_reg;
      endcase
    end
    case (st_reg)
      I2M_ST_IDLE: begin
        cnt_next = 20'h0;
        bit_next = 4'h0;
        if (!mode_ok) begin
          drv_next = '0;
          cmd_next = 4'h0;
        end else if (cmd_reg != 4'h0) begin
          drv_next.scl_low = 1'b1;
          if (cmd_reg[`I2M_CMD_START]) st_next = I2M_ST_START;
          if (cmd_reg[`I2M_CMD_STOP]) st_next = I2M_ST_STOP;
          if (cmd_reg[`I2M_CMD_RECV]) st_next = I2M_ST_BITS;
          if (is_send) begin
            st_next = I2M_ST_BITS;
            shift_next = data_reg;
            // a byte written in this very cycle stays pending for the next send
            tx_full_next = wr_en && (wr_addr == `I2M_OFF_DATA);
            stat_next[`I2M_ST_NACK] = 1'b0;
            evt_set[`I2M_EV_UND] = !tx_full_reg;
          end
        end
      end
      I2M_ST_START, I2M_ST_BITS, I2M_ST_STOP: begin
        if (!mode_ok) begin
          st_next = I2M_ST_IDLE;
          drv_next = '0;
          cmd_next = 4'h0;
        end else if (tick && !stall) begin
          cnt_next = cnt_reg + 20'h1;
          if (cnt_reg == q1) begin
            case (st_reg)
              I2M_ST_START: drv_next.sda_low = 1'b0;
              I2M_ST_STOP: drv_next.sda_low = 1'b1;
              default: begin
                if (bit_reg == 4'h8) drv_next.sda_low = is_send ? 1'b0 : ack_ctl_reg;
                else drv_next.sda_low = is_send ? !shift_reg[7] : 1'b0;
              end
            endcase
          end
          // release as the count reaches half, so low lasts exactly half a period
          if (cnt_reg == half - 20'h1) drv_next.scl_low = 1'b0;
          if (cnt_reg == q3) begin
            if (st_reg == I2M_ST_START) drv_next.sda_low = 1'b1;
            if (st_reg == I2M_ST_STOP) drv_next.sda_low = 1'b0;
            if (st_reg == I2M_ST_BITS && bit_reg == 4'h8 && is_send) stat_next[`I2M_ST_NACK] = sda_s2_reg;
            if (st_reg == I2M_ST_BITS && bit_reg != 4'h8 && !is_send) shift_next = {shift_reg[6:0], sda_s2_reg};
          end
          if (cnt_reg >= per - 20'h1) begin
            cnt_next = 20'h0;
            drv_next.scl_low = (st_reg != I2M_ST_STOP);
            if (st_reg == I2M_ST_BITS && is_send) shift_next = {shift_reg[6:0], 1'b0};
            bit_next = bit_reg + 4'h1;
            if (st_reg != I2M_ST_BITS || bit_reg == 4'h8) begin
              st_next = I2M_ST_IDLE;
              cmd_next = 4'h0;
              if (st_reg != I2M_ST_BITS) stat_next[`I2M_ST_CMDFIN] = 1'b1;
              else if (is_send) stat_next[`I2M_ST_TXFIN] = 1'b1;
              else begin
                stat_next[`I2M_ST_RXFIN] = 1'b1;
                if (rx_full_reg) evt_set[`I2M_EV_OVR] = 1'b1;
                else begin
                  data_next = shift_reg;
                  rx_full_next = 1'b1;
                end
              end
            end
          end
        end
      end
      default: st_next = I2M_ST_IDLE;
    endcase
    evt_set[3:0] = stat_next & ~stat_reg;
    evt_next = evt_reg | evt_set;
    if (wr_en && wr_addr == `I2M_OFF_EVT) evt_next = (evt_reg & ~wd[5:0]) | evt_set;
    irq_next = top_en_reg && |(evt_reg & evt_en_reg);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      {scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg} <= 4'hf;
      st_reg <= I2M_ST_IDLE;
      acc_reg <= 18'h0;
      cnt_reg <= 20'h0;
      bit_reg <= 4'h0;
      drv_reg <= '0;
      shift_reg <= 8'h0;
      mode_reg <= 2'h0;
      lin_reg <= `I2M_RST_LIN; // reset divider gives the standard rate
      pow_reg <= `I2M_RST_POW;
      cmd_reg <= 4'h0;
      stat_reg <= 4'h0;
      ack_ctl_reg <= 1'b0;
      data_reg <= 8'h0;
      tx_full_reg <= 1'b0;
      rx_full_reg <= 1'b0;
      evt_reg <= 6'h0;
      evt_en_reg <= 6'h0;
      top_en_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      scl_s1_reg <= scl_i;
      scl_s2_reg <= scl_s1_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
      st_reg <= st_next;
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      drv_reg <= drv_next;
      shift_reg <= shift_next;
      mode_reg <= mode_next;
      lin_reg <= lin_next;
      pow_reg <= pow_next;
      cmd_reg <= cmd_next;
      stat_reg <= stat_next;
      ack_ctl_reg <= ack_ctl_next;
      data_reg <= data_next;
      tx_full_reg <= tx_full_next;
      rx_full_reg <= rx_full_next;
      evt_reg <= evt_next;
      evt_en_reg <= evt_en_next;
      top_en_reg <= top_en_next;
      irq_reg <= irq_next;
    end
  end

  // open drain: the driven level is always low, enable decides
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = drv_reg.scl_low;
  assign sda_oe = drv_reg.sda_low; // line never compared with drive: no arbitration
  assign irq = irq_reg;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_mode_gate_idle: assert property (mode_reg != `I2M_MODE_I2C |=> st_reg == I2M_ST_IDLE)
    else $error("engine ran outside i2c mode");
  a_cmd_one_hot: assert property ($onehot0(cmd_reg))
    else $error("more than one segment command pending");
  a_cmd_fin_set: assert property ($fell(cmd_reg[`I2M_CMD_START]) && mode_ok |-> stat_reg[`I2M_ST_CMDFIN])
    else $error("start cleared without command finished");
  a_tx_fin_set: assert property ($fell(cmd_reg[`I2M_CMD_SEND]) && mode_ok |-> stat_reg[`I2M_ST_TXFIN])
    else $error("send cleared without transmit finished");
  a_rx_fin_set: assert property ($fell(cmd_reg[`I2M_CMD_RECV]) && mode_ok |-> stat_reg[`I2M_ST_RXFIN])
    else $error("receive cleared without receive finished");
  a_ack_slot_drive: assert property (st_reg == I2M_ST_BITS && !is_send && bit_reg == 4'h8 && cnt_reg > q1
    |-> sda_oe == ack_ctl_reg)
    else $error("ack slot not driven per acknowledge control");
  a_tx_ack_release: assert property (st_reg == I2M_ST_BITS && is_send && bit_reg == 4'h8 && cnt_reg > q1
    |-> !sda_oe)
    else $error("sda held during slave ack slot");
  a_fin_event: assert property ($rose(stat_reg[`I2M_ST_TXFIN]) |-> evt_reg[`I2M_ST_TXFIN])
    else $error("transmit finished rise gave no event");
  a_nack_event: assert property ($rose(stat_reg[`I2M_ST_NACK]) |-> evt_reg[`I2M_ST_NACK])
    else $error("nack gave no event");
  a_irq_gating: assert property (irq |-> $past(top_en_reg) && $past(|(evt_reg & evt_en_reg)))
    else $error("interrupt without both enables");
endmodule : i2m_master

// *** hw/i2m_cfg.svh ***
// i2m_cfg.svh: offsets, field positions, reset values and timing for the segment-based i2c master.
// assumes byte addressing on a 32-bit axi4-lite bus, one word per register.
`ifndef I2M_CFG_SVH
`define I2M_CFG_SVH
// register byte offsets
`define I2M_OFF_MODE 8'h00
`define I2M_OFF_LIN 8'h04
`define I2M_OFF_POW 8'h08
`define I2M_OFF_CMD 8'h0c
`define I2M_OFF_OPT 8'h10
`define I2M_OFF_STAT 8'h14
`define I2M_OFF_DATA 8'h18
`define I2M_OFF_EVT 8'h1c
`define I2M_OFF_EVTEN 8'h20
`define I2M_OFF_TOPEN 8'h24
// command register bits
`define I2M_CMD_START 0
`define I2M_CMD_SEND 1
`define I2M_CMD_RECV 2
`define I2M_CMD_STOP 3
// status register bits
`define I2M_ST_CMDFIN 0
`define I2M_ST_TXFIN 1
`define I2M_ST_RXFIN 2
`define I2M_ST_NACK 3
// event register bits 0..3 follow status, then these two
`define I2M_EV_OVR 4
`define I2M_EV_UND 5
// mode value that selects the i2c master
`define I2M_MODE_I2C 2'h3
// reset values: 100 kbps divider setting
`define I2M_RST_LIN 4'he
`define I2M_RST_POW 4'h3
// rates in khz: 12 mhz reference made from the system clock
`define I2M_REF_KHZ 18'd12000
`define I2M_CLK_KHZ 18'd200000
// axi responses
`define I2M_RESP_OKAY 2'h0
`define I2M_RESP_SLVERR 2'h2
`endif

// *** hw/i2m_pkg.sv ***
// i2m_pkg: types shared by the segment-based i2c master.
// assumes i2m_cfg.svh holds all numeric constants.
package i2m_pkg;
  typedef enum logic [3:0] {
    I2M_ST_IDLE = 4'b0001,
    I2M_ST_START = 4'b0010,
    I2M_ST_BITS = 4'b0100,
    I2M_ST_STOP = 4'b1000
  } i2m_state_t;

  // open-drain pin drive pair, 1 = pull low
  typedef struct packed {
    logic scl_low;
    logic sda_low;
  } i2m_drive_t;
endpackage : i2m_pkg

// *** test/i2m_slave_model.sv ***
// i2m_slave_model: behavioural i2c slave on the far side of the master's pins.
// assumes the bench resolves both wire levels with pull-ups and feeds them back here.
`timescale 1ns/100ps
module i2m_slave_model import i2m_pkg::*; #(
  parameter logic [6:0] ADDR = 7'h7a
) (
  // resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // behaviour controls
  input wire logic nack_all,
  input wire logic slow,
  input wire logic [7:0] tx_byte,
  // pin pulls, 1 = pull low
  output logic sda_low,
  output logic scl_low,
  // observations
  output logic [7:0] rx_byte,
  output logic m_ack
);
  logic ps = 1'b1;
  logic pd = 1'b1;
  logic act = 1'b0;
  logic first = 1'b0;
  logic rd = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h0;

  initial begin
    sda_low = 1'b0;
    scl_low = 1'b0;
    rx_byte = 8'h0;
    m_ack = 1'b0;
  end

  // ----------------------------------------
  // bit engine on level changes
  // ----------------------------------------
  always @(scl or sda) begin
    if (scl && ps && pd && !sda) begin
      first = 1'b1;
      act = 1'b1;
      rd = 1'b0;
      cnt = 4'h0;
    end else if (scl && ps && !pd && sda) begin
      act = 1'b0;
    end else if (scl && !ps) begin
      if (cnt == 4'h8) begin
        cnt = 4'h0;
        if (first) begin
          act = (sh[7:1] == ADDR);
          rd = sh[0];
          first = 1'b0;
        end else if (rd) begin
          m_ack = !sda;
          // a master nack ends the read, so sda is free for stop
          act = !sda;
        end else begin
          rx_byte = sh;
        end
      end else begin
        sh = {sh[6:0], sda};
        cnt = cnt + 4'h1;
      end
    end else if (!scl && ps) begin
      if (!act) sda_low = 1'b0;
      else if (cnt == 4'h8) sda_low = first ? (sh[7:1] == ADDR) : (!rd && !nack_all);
      else sda_low = rd && !first && !tx_byte[3'h7 - cnt[2:0]];
    end
    ps = scl;
    pd = sda;
  end

  // slow answer: hold the clock low after each fall
  always @(negedge scl) begin
    if (slow) begin
      scl_low = 1'b1;
      #500 scl_low = 1'b0;
    end
  end
endmodule : i2m_slave_model

// *** test/i2m_master_tb.sv ***
// i2m_master_tb: self-checking bench for the segment i2c master over axi4-lite.
// assumes i2m_slave_model on the pins and pull-ups on both lines.
`timescale 1ns/100ps
`include "i2m_cfg.svh"
module i2m_master_tb import i2m_pkg::*; ;
  localparam int DIV_LIN = 14;
  localparam int DIV_POW = 1;
  localparam logic [7:0] OFF_POW = 8'h08;
  localparam logic [3:0] C_ST = 4'h1 << `I2M_CMD_START;
  localparam logic [3:0] C_TX = 4'h1 << `I2M_CMD_SEND;
  localparam logic [3:0] C_RX = 4'h1 << `I2M_CMD_RECV;
  localparam logic [3:0] C_SP = 4'h1 << `I2M_CMD_STOP;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, tx_byte = 8'h0, rx_byte;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d, seed = 32'h02a9;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic scl_oe, sda_oe, irq, scl, sda, slv_sda_low, slv_scl_low, m_ack;
  logic nack_all = 1'b0, slow = 1'b0;
  logic [63:0] exp_rd[$];
  logic [1:0] exp_br[$];
  logic [63:0] ent;
  int mismatches = 0, compares = 0;
  real t0, t1, per;

  always #2.5 clk_sys = !clk_sys;
  assign scl = !(scl_oe || slv_scl_low); // one master only, pull-up
  assign sda = !(sda_oe || slv_sda_low);

  i2m_master dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .irq(irq));

  i2m_slave_model slv_u (.scl(scl), .sda(sda), .nack_all(nack_all), .slow(slow), .tx_byte(tx_byte),
    .sda_low(slv_sda_low), .scl_low(slv_scl_low), .rx_byte(rx_byte), .m_ack(m_ack));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // tolerance covers tick jitter and the pin synchroniser
  function automatic logic [31:0] near(input real x, input real y);
    return {31'h0, (x > y - 30.0) && (x < y + 30.0)};
  endfunction : near

  task automatic print_verdict();
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `I2M_RESP_OKAY);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    exp_br.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge clk_sys);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_rd.push_back({m, e & m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
  endtask : axi_rd

  // polls until the engine clears the command bit
  task automatic wait_idle();
    rd_d = 32'h1;
    while (rd_d[3:0] !== 4'h0) axi_rd(`I2M_OFF_CMD, 32'h0, 32'h0);
  endtask : wait_idle

  task automatic seg(input logic [3:0] c);
    axi_wr(`I2M_OFF_CMD, {28'h0, c});
    wait_idle();
  endtask : seg

  always @(posedge clk_sys) begin
    if (s_axi_rvalid) begin
      ent = exp_rd.pop_front();
      cmp("rdata", ent[31:0], s_axi_rdata & ent[63:32]);
    end
    if (s_axi_bvalid) cmp("bresp", {30'h0, exp_br.pop_front()}, {30'h0, s_axi_bresp});
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++) axi_rd(8'(i * 4), 32'hff, (i == 1) ? 32'he : (i == 2) ? 32'h3 : 32'h0);
    axi_wr(8'h28, 32'h1, `I2M_RESP_SLVERR);
    axi_wr(`I2M_OFF_STAT, 32'hf, `I2M_RESP_SLVERR);
    axi_wr(`I2M_OFF_CMD, {28'h0, C_ST});
    axi_rd(`I2M_OFF_CMD, 32'hf, 32'h0);
    cmp("scl_level", 32'h1, {31'h0, scl});
    axi_wr(`I2M_OFF_MODE, {30'h0, `I2M_MODE_I2C});
    axi_wr(`I2M_OFF_LIN, 32'(DIV_LIN));
    axi_wr(OFF_POW, 32'(DIV_POW));
    axi_wr(`I2M_OFF_CMD, 32'h5);
    axi_rd(`I2M_OFF_CMD, 32'hf, 32'h0);
    seg(C_ST);
    axi_rd(`I2M_OFF_STAT, 32'h7, 32'h1);
    axi_wr(`I2M_OFF_DATA, {24'h0, 5'h1e, 2'b10, 1'b0}); // ten-bit address, write
    axi_wr(`I2M_OFF_CMD, {28'h0, C_TX});
    @(posedge scl);
    t0 = $realtime;
    @(negedge scl);
    t1 = $realtime;
    @(posedge scl);
    per = 1.0e6 / `I2M_REF_KHZ * ((DIV_LIN + 1) << DIV_POW);
    cmp("scl_period", 32'h1, near($realtime - t0, per));
    cmp("scl_low", 32'h1, near($realtime - t1, per / 2.0));
    @(posedge clk_sys);
    wait_idle();
    axi_rd(`I2M_OFF_STAT, 32'hf, 32'h2);
    seed = lfsr(seed);
    axi_wr(`I2M_OFF_DATA, {24'h0, seed[7:0]});
    seg(C_TX);
    cmp("slave_rx", {24'h0, seed[7:0]}, {24'h0, rx_byte});
    seg(C_TX); // nothing written: underrun
    nack_all <= 1'b1;
    axi_wr(`I2M_OFF_DATA, {24'h0, seed[15:8]});
    seg(C_TX);
    axi_rd(`I2M_OFF_STAT, 32'ha, 32'ha);
    nack_all <= 1'b0;
    seg(C_SP);
    axi_rd(`I2M_OFF_STAT, 32'h7, 32'h1);
    cmp("bus_free", 32'h1, {31'h0, scl && sda});
    seed = lfsr(seed);
    tx_byte <= seed[7:0];
    seg(C_ST);
    axi_wr(`I2M_OFF_DATA, {24'h0, 7'h7a, 1'b1}); // seven-bit address, read
    seg(C_TX);
    axi_wr(`I2M_OFF_OPT, 32'h1);
    slow <= 1'b1;
    seg(C_RX);
    slow <= 1'b0;
    axi_rd(`I2M_OFF_STAT, 32'h7, 32'h4);
    cmp("master_ack", 32'h1, {31'h0, m_ack});
    axi_wr(`I2M_OFF_OPT, 32'h0);
    seg(C_RX); // first byte unread: overrun
    cmp("master_ack", 32'h0, {31'h0, m_ack});
    axi_rd(`I2M_OFF_DATA, 32'hff, {24'h0, tx_byte});
    seg(C_SP);
    axi_rd(`I2M_OFF_EVT, 32'h3f, 32'h3f);
    cmp("irq", 32'h0, {31'h0, irq});
    axi_wr(`I2M_OFF_EVTEN, 32'h3f);
    repeat (2) @(posedge clk_sys);
    cmp("irq", 32'h0, {31'h0, irq}); // top level still off
    axi_wr(`I2M_OFF_TOPEN, 32'h1);
    repeat (2) @(posedge clk_sys);
    cmp("irq", 32'h1, {31'h0, irq});
    axi_wr(`I2M_OFF_EVT, 32'h3f);
    repeat (2) @(posedge clk_sys);
    cmp("irq", 32'h0, {31'h0, irq});
    print_verdict();
  end

  // the whole sequence needs a little under half this span
  initial begin
    #400us;
    mismatches++;
    print_verdict();
  end
endmodule : i2m_master_tb
